// ===== dv/board_power_model.sv
// Board logic that cuts the core supply after a trip
`timescale 1ns/100ps
`default_nettype none
module board_power_model (
  input wire logic clk,
  input wire logic pon,
  input wire logic n,
  input wire logic oe,
  output logic ok
);
  logic [5:0] held = 6'h00; // Delay lets the latch be watched first
  always @(posedge clk)
    held <= pon ? held + {5'h00, !n && oe && !held[5]} : 6'h00;
  assign ok = pon && !held[5];
endmodule // board_power_model

// ===== dv/thermal_trip_latch_assertions.sv
// Assertions for the thermal shutdown latch
`timescale 1ns/100ps
`default_nettype none
`include "thermal_trip_defs.svh"
module thermal_trip_latch_assertions import thermal_trip_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire logic supply_ok,
  input wire temp_pair_t temps,
  input wire logic thermal_shutdown_n,
  input wire logic thermal_shutdown_oe,
  input wire logic core_clock_stop
);
  localparam int enable_limit = `ENABLE_LIMIT_CYCLES;
  wire logic n = thermal_shutdown_n;
  wire logic oe = thermal_shutdown_oe;
  wire logic ok = supply_ok;
  wire logic hot = {1'b0, temps.die_temp} >=
    {1'b0, temps.case_max} + 9'(`TRIP_MARGIN_C);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Powered cycles without drive; 10 us is too long for a delay range
  int ok_run;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) ok_run <= 0;
    else if (ok && !oe) ok_run <= ok_run + 1;
    else ok_run <= 0;
  end
  // Six stable hot cycles cover sync, latch and output stages
  sequence s_hot; (hot && ok && oe) [*6]; endsequence
  // Three powered samples rule out a clear still in the synchroniser
  sequence s_ok_steady; ok [*3]; endsequence
  a_oe_late: assert property (ok && !oe |-> ok_run < enable_limit)
    else $error("late enable");
  a_oe_off: assert property (!ok [*3] |=> !oe) else $error("oe on");
  a_idle_high: assert property (!oe |-> n) else $error("low idle");
  a_clk_stop: assert property ($fell(n) |-> core_clock_stop)
    else $error("clocks run");
  a_stop_trip: assert property (core_clock_stop |-> !n)
    else $error("stop without trip");
  a_trip_held: assert property (s_ok_steady ##0 !n |=> !n)
    else $error("trip lost");
  a_trip_fast: assert property (s_hot |-> !n)
    else $error("no trip");
endmodule // thermal_trip_latch_assertions

// ===== dv/thermal_trip_latch_tb_top.sv
// Self-checking bench for the thermal shutdown latch
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; \
  $display("unexpected %0t bad value", $time); end end
module thermal_trip_latch_tb_top;
  import thermal_trip_pkg::*;
  logic clk = 0, rstn = 0, pon = 0, ok, n, oe, stop;
  temp_pair_t temps = 16'h0000;
  int mismatches = 0, checks_done = 0;
  logic [16:0] rows [4] = '{{8'h50, 8'h3c, 1'b1}, {8'h4f, 8'h3c, 1'b0},
    {8'hff, 8'hf0, 1'b0}, {8'h14, 8'h00, 1'b1}}; // Last row must trip
  thermal_trip_latch i_thermal_trip_latch (.clk, .rstn, .supply_ok(ok),
    .temps, .thermal_shutdown_n(n), .thermal_shutdown_oe(oe),
    .core_clock_stop(stop));
  board_power_model i_board_power_model (.clk, .pon, .n, .oe, .ok);
  task automatic tk(input int c); repeat (c) @(posedge clk); #1; endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial forever #4 clk = ~clk;
  initial begin #20000; mismatches++; wrap_up; end
  initial begin
    tk(12); `CHK({n, oe, stop}, 3'b100)
    $display("reset case done");
    rstn = 1;
    for (int i = 0; i < 4; i++) begin
      pon = 0; tk(8); temps = rows[i][16:1]; pon = 1; tk(28);
      `CHK({oe, n, stop}, {1'b1, !rows[i][0], rows[i][0]})
      $display("row %0d done", i);
    end
    temps = 16'h0000; tk(10); `CHK(n, 1'b0)
    tk(60); `CHK({n, oe, stop}, 3'b100)
    temps = 16'h1400; pon = 0; tk(8); pon = 1; tk(28); `CHK(n, 1'b0)
    $display("latch cases done");
    wrap_up;
  end
endmodule // thermal_trip_latch_tb_top
bind thermal_trip_latch thermal_trip_latch_assertions i_chk (.clk, .rstn,
  .supply_ok, .temps, .thermal_shutdown_n, .thermal_shutdown_oe,
  .core_clock_stop);
`default_nettype wire

// ===== shared/thermal_trip_defs.svh
// Timing and layout constants for the thermal shutdown latch
`ifndef THERMAL_TRIP_DEFS_SVH
`define THERMAL_TRIP_DEFS_SVH
// =====================================================================
// Clock and timing
`define CLK_PERIOD_NS 8
`define ENABLE_LIMIT_US 10
// Longest time rounds down: 10000 ns / 8 ns = 1250 cycles
`define ENABLE_LIMIT_CYCLES ((`ENABLE_LIMIT_US * 1000) / `CLK_PERIOD_NS)
// Enable is granted after this many cycles of stable supply_ok
`define ENABLE_DELAY_CYCLES 16
`define COUNT_W 11
// =====================================================================
// Trip margin above maximum case temperature, degrees C
`define TRIP_MARGIN_C 20
`define TEMP_W 8
`endif

// ===== shared/thermal_trip_pkg.sv
// Types for the thermal shutdown latch
`default_nettype none
package thermal_trip_pkg;
  // ===================================================================
  // Power sequencing states
  typedef enum logic [1:0] {
    st_off = 2'b00,
    st_wait = 2'b01,
    st_armed = 2'b10
  } power_state_t;
  // Temperature inputs travel together
  typedef struct packed {
    logic [7:0] die_temp;
    logic [7:0] case_max;
  } temp_pair_t;
endpackage
`default_nettype wire

// ===== verilog/thermal_trip_latch.sv
// Catastrophic over-temperature shutdown latch with supply_ok gating
`timescale 1ns/100ps
`default_nettype none
`include "thermal_trip_defs.svh"
// =====================================================================
module thermal_trip_latch
  import thermal_trip_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic supply_ok,
  input wire temp_pair_t temps,
  output logic thermal_shutdown_n,
  output logic thermal_shutdown_oe,
  output logic core_clock_stop
);

  // ===================================================================
  // Synchronisers for pin-level inputs
  // Temperature codes must move slowly; a word caught mid-change
  // may compare wrongly for one cycle, and the latch cannot undo it
  logic ok_sync;
  temp_pair_t temps_sync;

  sync_two_stage #(
    .W(1)
  ) i_sync_two_stage_ok (
    .clk(clk),
    .rstn(rstn),
    .d(supply_ok),
    .q(ok_sync)
  );

  sync_two_stage #(
    .W($bits(temp_pair_t))
  ) i_sync_two_stage_temps (
    .clk(clk),
    .rstn(rstn),
    .d(temps),
    .q(temps_sync)
  );

  // ===================================================================
  // Trip comparison, widened so the margin never wraps
  logic [`TEMP_W:0] die_wide;
  logic [`TEMP_W:0] case_wide;
  logic [`TEMP_W:0] margin_wide;
  logic [`TEMP_W:0] trip_level;
  logic hot;

  assign die_wide = {1'b0, temps_sync.die_temp};
  assign case_wide = {1'b0, temps_sync.case_max};
  assign margin_wide = (`TEMP_W+1)'(`TRIP_MARGIN_C);
  assign trip_level = case_wide + margin_wide;
  assign hot = (die_wide >= trip_level);

  // ===================================================================
  // Power sequencing: delay is far below the limit, leaving margin
  power_state_t state;
  power_state_t next_state;
  logic [`COUNT_W-1:0] wait_count;
  logic [`COUNT_W-1:0] next_wait_count;
  logic wait_done;
  logic supply_lost;
  localparam logic [`COUNT_W-1:0] delay_last =
    `COUNT_W'(`ENABLE_DELAY_CYCLES - 1);

  assign supply_lost = !ok_sync;
  assign wait_done = (wait_count == delay_last);

  always_comb begin
    next_state = state;
    case (state)
      st_off: begin
        if (ok_sync) begin
          next_state = st_wait;
        end
      end
      st_wait: begin
        if (supply_lost) begin
          next_state = st_off;
        end else if (wait_done) begin
          next_state = st_armed;
        end
      end
      st_armed: begin
        if (supply_lost) begin
          next_state = st_off;
        end
      end
      default: begin
        next_state = st_off;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= st_off;
    end else begin
      state <= next_state;
    end
  end

  // ===================================================================
  // Enable delay counter, cleared outside the waiting state
  always_comb begin
    if (state == st_wait) begin
      next_wait_count = wait_count + `COUNT_W'(1);
    end else begin
      next_wait_count = '0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wait_count <= '0;
    end else begin
      wait_count <= next_wait_count;
    end
  end

  // ===================================================================
  // Trip latch: temperature only sets it, losing supply_ok clears it
  // The clear wins a same-cycle trip, since the pin is undriven then
  logic tripped;
  logic next_tripped;
  logic armed;
  logic trip_event;

  assign armed = (state == st_armed);
  assign trip_event = armed && hot;

  always_comb begin
    next_tripped = tripped;
    if (supply_lost) begin
      next_tripped = 1'b0;
    end else if (trip_event) begin
      next_tripped = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tripped <= 1'b0;
    end else begin
      tripped <= next_tripped;
    end
  end

  // ===================================================================
  // Output next values; the latch reaches the pin one cycle later
  logic next_oe;
  logic next_shutdown_n;
  logic next_clock_stop;

  assign next_oe = (next_state == st_armed);
  assign next_shutdown_n = !(tripped && next_oe);
  assign next_clock_stop = tripped && ok_sync;

  // ===================================================================
  // Driver enable
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      thermal_shutdown_oe <= 1'b0;
    end else begin
      thermal_shutdown_oe <= next_oe;
    end
  end

  // ===================================================================
  // Trip output, deasserted whenever the driver is off
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      thermal_shutdown_n <= 1'b1;
    end else begin
      thermal_shutdown_n <= next_shutdown_n;
    end
  end

  // ===================================================================
  // Clock stop; removing the core supply is left to the board
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      core_clock_stop <= 1'b0;
    end else begin
      core_clock_stop <= next_clock_stop;
    end
  end

endmodule // thermal_trip_latch

// =====================================================================
// Two-flop synchroniser; only the second stage is visible outside
module sync_two_stage #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule // sync_two_stage
`default_nettype wire
